// ### bfcf_mem.sv
// Purpose: Shared constants and types for the two-way clocked FIFO block,
//          and the word store that backs one direction of it.
// Assumes: One system clock clk; both port clocks are sampled inputs.
// Notes:   The store has no reset on its array; only its read register resets.
`timescale 1ns/100ps
`default_nettype none

package bfcf_pkg;
	localparam int          DATA_W      = 18;
	localparam int          ADDR_W      = 9;
	localparam int          DEPTH       = 512;
	localparam logic [10:0] DEPTH_WORDS = 11'h200;
	localparam logic [10:0] HALF_WORDS  = 11'h100;
	localparam logic [7:0]  OFFSET_RST  = 8'h80;
	localparam logic [1:0]  IR_EDGES    = 2'h2;
	localparam logic [1:0]  OR_WAIT     = 2'h2;

	typedef enum logic [2:0] {
		PROG_FIRST  = 3'b001,
		PROG_SECOND = 3'b010,
		PROG_DONE   = 3'b100
	} bfcf_prog_t;

	typedef struct packed {
		logic [9:0]  wrPtr;
		logic [9:0]  rdPtr;
		logic [9:0]  avail;
		logic        inReady;
		logic        outReady;
		logic [17:0] outWord;
		logic        halfFull;
		logic        almost;
		logic [1:0]  irCnt;
		logic [1:0]  fallCnt;
		logic        progOpen;
		bfcf_prog_t  prog;
		logic [7:0]  offX;
		logic [7:0]  offY;
	} bfcf_dir_t;

	localparam bfcf_dir_t DIR_RST = '{
		wrPtr: 10'h0, rdPtr: 10'h0, avail: 10'h0, inReady: 1'b0,
		outReady: 1'b0, outWord: 18'h0, halfFull: 1'b0, almost: 1'b1,
		irCnt: 2'h0, fallCnt: 2'h0, progOpen: 1'b1, prog: PROG_FIRST,
		offX: OFFSET_RST, offY: OFFSET_RST};

	typedef struct packed {
		bfcf_dir_t ab;
		bfcf_dir_t ba;
		logic      clkAQ;
		logic      clkBQ;
		logic      aOe;
		logic      bOe;
	} bfcf_state_t;

	localparam bfcf_state_t STATE_RST = '{
		ab: DIR_RST, ba: DIR_RST, clkAQ: 1'b0, clkBQ: 1'b0, aOe: 1'b1, bOe: 1'b1};
endpackage

////////////////////////////////////////////////////////////////////////////////

module bfcf_mem #(
	parameter int WIDTH  = bfcf_pkg::DATA_W,
	parameter int ADDR_W = bfcf_pkg::ADDR_W,
	parameter int DEPTH  = bfcf_pkg::DEPTH
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              arst_n,
	// Write side
	input  wire logic              wrEn,
	input  wire logic [ADDR_W-1:0] wrAddr,
	input  wire logic [WIDTH-1:0]  wrData,
	// Read side
	input  wire logic [ADDR_W-1:0] rdAddr,
	output var  logic [WIDTH-1:0]  rdData
);
	logic [WIDTH-1:0] store [DEPTH];

	always_ff @(posedge clk) begin
		if (wrEn) begin
			store[wrAddr] <= wrData;
		end
	end

	// The read word trails the address by one clock.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdData <= '0;
		end else begin
			rdData <= store[rdAddr];
		end
	end
endmodule

`default_nettype wire

// ### bfcf_top.sv
// Purpose: Flag, handshake and queue control for a two-way clocked FIFO with
//          one queue from port A to port B and one from port B to port A.
// Assumes: clk is much faster than either port clock, so every port clock
//          edge is seen as a distinct low-to-high step of the sampled pin.
// Notes:   Port clocks are sampled inputs; all state runs on clk.
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module bfcf_top (
	// System clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Port A control
	input  wire logic        portAClock,
	input  wire logic        portASelectN,
	input  wire logic        portADirection,
	input  wire logic        aWriteEnable,
	input  wire logic        aReadEnable,
	input  wire logic        aOffsetProgramN,
	input  wire logic        aToBResetN,
	// Port A data pins
	input  wire logic [17:0] portADataIn,
	output wire logic [17:0] portADataOut,
	output wire logic        portADataOe,
	// Port A flags
	output wire logic        aInputReady,
	output wire logic        aOutputReady,
	output wire logic        aToBHalfFull,
	output wire logic        aToBAlmostFlag,
	// Port B control
	input  wire logic        portBClock,
	input  wire logic        portBSelectN,
	input  wire logic        portBDirection,
	input  wire logic        bWriteEnable,
	input  wire logic        bReadEnable,
	input  wire logic        bOffsetProgramN,
	input  wire logic        bToAResetN,
	// Port B data pins
	input  wire logic [17:0] portBDataIn,
	output wire logic [17:0] portBDataOut,
	output wire logic        portBDataOe,
	// Port B flags
	output wire logic        bInputReady,
	output wire logic        bOutputReady,
	output wire logic        bToAHalfFull,
	output wire logic        bToAAlmostFlag
);
	bfcf_pkg::bfcf_state_t st_r;
	bfcf_pkg::bfcf_state_t st_nxt;
	logic                  aEdge;
	logic                  bEdge;
	logic                  abWrAcc;
	logic                  abRdAcc;
	logic                  baWrAcc;
	logic                  baRdAcc;
	logic [17:0]           abMemData;
	logic [17:0]           baMemData;

	////////////////////////////////////////////////////////////////////////////
	// One queue direction: write side, read side, programming and flags.

	function automatic bfcf_pkg::bfcf_dir_t stepDir(
		input bfcf_pkg::bfcf_dir_t s,
		input logic                rstN,
		input logic                wrEdge,
		input logic                rdEdge,
		input logic                wrAcc,
		input logic                rdAcc,
		input logic                progN,
		input logic [7:0]          progData,
		input logic [17:0]         memData
	);
		bfcf_pkg::bfcf_dir_t n;
		logic [10:0]         total;
		logic                memHas;
		n = s;
		// A word counts as present once it has sat in the store one clock,
		// so the store's read register already holds it.
		memHas = (s.avail != 10'h0);
		n.avail = s.wrPtr - s.rdPtr;
		if (wrAcc) begin
			n.wrPtr = s.wrPtr + 10'h1;
			n.progOpen = 1'b0;
		end
		// Offsets may only be loaded between the reset and the first write.
		if (wrEdge && s.progOpen) begin
			if (progN) begin
				n.prog = bfcf_pkg::PROG_FIRST;
			end else begin
				case (s.prog)
					bfcf_pkg::PROG_FIRST: begin
						n.offX = progData;
						n.offY = progData;
						n.prog = bfcf_pkg::PROG_SECOND;
					end
					bfcf_pkg::PROG_SECOND: begin
						n.offY = progData;
						n.prog = bfcf_pkg::PROG_DONE;
					end
					bfcf_pkg::PROG_DONE: begin
						n.prog = bfcf_pkg::PROG_DONE;
					end
					default: begin
						n.prog = bfcf_pkg::PROG_FIRST;
					end
				endcase
			end
		end
		if (rdEdge) begin
			if (s.outReady) begin
				if (rdAcc) begin
					if (memHas) begin
						n.outWord = memData;
						n.rdPtr = s.rdPtr + 10'h1;
					end else begin
						n.outReady = 1'b0;
					end
					n.fallCnt = 2'h0;
				end
			end else if (!memHas) begin
				n.fallCnt = 2'h0;
			end else if (s.fallCnt == bfcf_pkg::OR_WAIT) begin
				// Third edge with a word waiting: it falls through.
				n.outWord = memData;
				n.rdPtr = s.rdPtr + 10'h1;
				n.outReady = 1'b1;
				n.fallCnt = 2'h0;
			end else begin
				n.fallCnt = s.fallCnt + 2'h1;
			end
		end
		total = {1'b0, n.wrPtr - n.rdPtr} + {10'h0, n.outReady};
		if (wrEdge) begin
			if (s.irCnt != bfcf_pkg::IR_EDGES) begin
				n.irCnt = s.irCnt + 2'h1;
				n.inReady = (n.irCnt == bfcf_pkg::IR_EDGES);
			end else begin
				n.inReady = (total < bfcf_pkg::DEPTH_WORDS);
			end
		end
		n.halfFull = (total >= bfcf_pkg::HALF_WORDS);
		n.almost = (total <= {3'h0, s.offX}) ||
			(total >= (bfcf_pkg::DEPTH_WORDS - {3'h0, s.offY}));
		// The queue reset clears pointers and the ready and half-full flags and sets the almost flag; the last word stays.
		if (!rstN) begin
			n = bfcf_pkg::DIR_RST;
			n.outWord = s.outWord;
		end
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Port clock edges and accepted transfers.

	always_comb begin
		aEdge = portAClock & ~st_r.clkAQ;
		bEdge = portBClock & ~st_r.clkBQ;
		abWrAcc = aEdge & aWriteEnable & portADirection & ~portASelectN &
			st_r.ab.inReady & aOffsetProgramN & aToBResetN;
		baRdAcc = aEdge & aReadEnable & ~portADirection & ~portASelectN &
			st_r.ba.outReady;
		baWrAcc = bEdge & bWriteEnable & portBDirection & ~portBSelectN &
			st_r.ba.inReady & bOffsetProgramN & bToAResetN;
		abRdAcc = bEdge & bReadEnable & ~portBDirection & ~portBSelectN &
			st_r.ab.outReady;
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.clkAQ = portAClock;
		st_nxt.clkBQ = portBClock;
		st_nxt.ab = stepDir(st_r.ab, aToBResetN, aEdge, bEdge, abWrAcc, abRdAcc,
			aOffsetProgramN, portADataIn[7:0], abMemData);
		st_nxt.ba = stepDir(st_r.ba, bToAResetN, bEdge, aEdge, baWrAcc, baRdAcc,
			bOffsetProgramN, portBDataIn[7:0], baMemData);
		// Pins are driven only when selected and set to read.
		st_nxt.aOe = portASelectN | portADirection;
		st_nxt.bOe = portBSelectN | portBDirection;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= bfcf_pkg::STATE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Word stores.

	bfcf_mem #(
		.WIDTH  (bfcf_pkg::DATA_W),
		.ADDR_W (bfcf_pkg::ADDR_W),
		.DEPTH  (bfcf_pkg::DEPTH)
	) uAbMem (
		.clk    (clk),
		.arst_n (arst_n),
		.wrEn   (abWrAcc),
		.wrAddr (st_r.ab.wrPtr[8:0]),
		.wrData (portADataIn),
		.rdAddr (st_r.ab.rdPtr[8:0]),
		.rdData (abMemData)
	);

	bfcf_mem #(
		.WIDTH  (bfcf_pkg::DATA_W),
		.ADDR_W (bfcf_pkg::ADDR_W),
		.DEPTH  (bfcf_pkg::DEPTH)
	) uBaMem (
		.clk    (clk),
		.arst_n (arst_n),
		.wrEn   (baWrAcc),
		.wrAddr (st_r.ba.wrPtr[8:0]),
		.wrData (portBDataIn),
		.rdAddr (st_r.ba.rdPtr[8:0]),
		.rdData (baMemData)
	);

	////////////////////////////////////////////////////////////////////////////
	// Outputs, all taken from the state register.

	assign portADataOut   = st_r.ba.outWord;
	assign portADataOe    = st_r.aOe;
	assign aInputReady    = st_r.ab.inReady;
	assign aOutputReady   = st_r.ba.outReady;
	assign aToBHalfFull   = st_r.ab.halfFull;
	assign aToBAlmostFlag = st_r.ab.almost;
	assign portBDataOut   = st_r.ab.outWord;
	assign portBDataOe    = st_r.bOe;
	assign bInputReady    = st_r.ba.inReady;
	assign bOutputReady   = st_r.ab.outReady;
	assign bToAHalfFull   = st_r.ba.halfFull;
	assign bToAAlmostFlag = st_r.ba.almost;

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	sequence seqAbWait;
		!bOutputReady && st_r.ab.fallCnt == 2'h2 && st_r.ab.avail != 10'h0;
	endsequence

	sequence seqBaWait;
		!aOutputReady && st_r.ba.fallCnt == 2'h2 && st_r.ba.avail != 10'h0;
	endsequence

	a_full_blocks_a: assert property (
		(!aInputReady && aToBResetN) |=> (st_r.ab.wrPtr == $past(st_r.ab.wrPtr)))
		else $error("A-to-B pointer moved while input ready low");

	a_full_blocks_b: assert property (
		(!bInputReady && bToAResetN) |=> (st_r.ba.wrPtr == $past(st_r.ba.wrPtr)))
		else $error("B-to-A pointer moved while input ready low");

	a_ab_reset_flags: assert property (
		(!aToBResetN) |=> (!aInputReady && !bOutputReady && !aToBHalfFull &&
			aToBAlmostFlag))
		else $error("A-to-B reset flags wrong");

	a_ba_reset_flags: assert property (
		(!bToAResetN) |=> (!bInputReady && !aOutputReady && !bToAHalfFull &&
			bToAAlmostFlag))
		else $error("B-to-A reset flags wrong");

	a_ir_second_edge: assert property (
		(aToBResetN && aEdge && st_r.ab.irCnt == 2'h1) |=> aInputReady)
		else $error("A input ready not raised on second edge");

	a_ab_fallthrough: assert property (
		(seqAbWait ##0 (bEdge && aToBResetN)) |=> (bOutputReady &&
			portBDataOut == $past(abMemData)))
		else $error("A-to-B word did not fall through on third edge");

	a_ba_fallthrough: assert property (
		(seqBaWait ##0 (aEdge && bToAResetN)) |=> (aOutputReady &&
			portADataOut == $past(baMemData)))
		else $error("B-to-A word did not fall through on third edge");

	a_or_rise_cause: assert property (
		$rose(aOutputReady) |-> ($past(aEdge) && $past(st_r.ba.fallCnt) == 2'h2))
		else $error("A output ready rose without three edges");

	a_a_word_holds: assert property (
		(!aOutputReady ##1 !aOutputReady) |-> $stable(portADataOut))
		else $error("Port A word changed while not ready");

	a_b_word_holds: assert property (
		(!bOutputReady ##1 !bOutputReady) |-> $stable(portBDataOut))
		else $error("Port B word changed while not ready");

	a_a_read_pop: assert property (
		(baRdAcc && bToAResetN && st_r.ba.avail != 10'h0) |=>
			(st_r.ba.rdPtr == $past(st_r.ba.rdPtr) + 10'h1))
		else $error("Port A read did not advance queue");

	a_b_read_pop: assert property (
		(abRdAcc && aToBResetN && st_r.ab.avail != 10'h0) |=>
			(st_r.ab.rdPtr == $past(st_r.ab.rdPtr) + 10'h1))
		else $error("Port B read did not advance queue");

	a_a_write_push: assert property (
		(aEdge && aWriteEnable && portADirection && !portASelectN && aInputReady &&
			aOffsetProgramN && aToBResetN) |=>
			(st_r.ab.wrPtr == $past(st_r.ab.wrPtr) + 10'h1))
		else $error("Port A write not taken");

	a_a_offset_load: assert property (
		(aEdge && !aOffsetProgramN && aToBResetN && st_r.ab.progOpen &&
			st_r.ab.prog == bfcf_pkg::PROG_FIRST) |=>
			(st_r.ab.offX == $past(portADataIn[7:0]) &&
			st_r.ab.offY == $past(portADataIn[7:0])))
		else $error("A offset not captured");

	a_b_offset_load: assert property (
		(bEdge && !bOffsetProgramN && bToAResetN && st_r.ba.progOpen &&
			st_r.ba.prog == bfcf_pkg::PROG_SECOND) |=>
			(st_r.ba.offY == $past(portBDataIn[7:0])))
		else $error("B second offset not captured");

	a_pins_release: assert property (
		(portASelectN || portBSelectN) |=> ((portADataOe || !$past(portASelectN)) &&
			(portBDataOe || !$past(portBSelectN))))
		else $error("Data pins driven while deselected");
endmodule

`default_nettype wire

// ### bfcf_port_model.sv
// Purpose: Bus-side partner for one port of the two-way FIFO block.
// Assumes: The port clock runs free, stepped on clk.
// Notes:   Undriven data pins show the inverse of their last value.
`timescale 1ns/100ps
`default_nettype none

module bfcf_port_model #(
	parameter int HALF = 4
) (
	// System clock
	input  wire logic        clk,
	// Port controls
	output var  logic        portClock   = 1'b0,
	output var  logic        selectN     = 1'b1,
	output var  logic        direction   = 1'b0,
	output var  logic        writeEnable = 1'b0,
	output var  logic        readEnable  = 1'b0,
	output var  logic        programN    = 1'b1,
	// Data pins
	output wire logic [17:0] dataIn,
	input  wire logic [17:0] dataOut,
	input  wire logic        dataOe
);
	int          cnt   = 0;
	logic        drive = 1'b0;
	logic [17:0] word  = 18'h0;
	logic [17:0] last  = 18'h0;

	assign dataIn = !dataOe ? dataOut : (drive ? word : ~last);

	always @(posedge clk) begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1) begin
			portClock <= ~portClock;
		end
		if (!dataOe || drive) begin
			last <= dataIn;
		end
	end

	////////////////////////////////////////
	// Controls change while the port clock is low and hold past its next rise.
	task automatic cycle(input logic sel, wr, we, rd, pg, input logic [17:0] d);
		@(negedge portClock);
		selectN     <= ~sel;
		direction   <= wr;
		writeEnable <= we;
		readEnable  <= rd;
		programN    <= ~pg;
		word        <= d;
		drive       <= wr;
		@(posedge portClock);
		@(posedge clk);
		selectN     <= 1'b1;
		writeEnable <= 1'b0;
		readEnable  <= 1'b0;
		drive       <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### tb.sv
// Purpose: Self-checking bench for the two-way FIFO flag and queue logic.
// Assumes: Port A clock period is 8 clk, port B 10 clk.
// Notes:   Queue resets span more than four edges of both port clocks.
`timescale 1ns/100ps
`default_nettype none

module tb;
	logic             clk         = 1'b0;
	logic             arst_n      = 1'b0;
	logic             aToBResetN  = 1'b0;
	logic             bToAResetN  = 1'b0;
	int               mismatches  = 0;
	int               comparisons = 0;
	int               cycles      = 0;
	wire logic        portAClock, portASelectN, portADirection, aWriteEnable, aReadEnable;
	wire logic        portBClock, portBSelectN, portBDirection, bWriteEnable, bReadEnable;
	wire logic        aOffsetProgramN, portADataOe, aInputReady, aOutputReady;
	wire logic        bOffsetProgramN, portBDataOe, bInputReady, bOutputReady;
	wire logic        aToBHalfFull, aToBAlmostFlag, bToAHalfFull, bToAAlmostFlag;
	wire logic [17:0] portADataIn, portADataOut, portBDataIn, portBDataOut;

	bfcf_top DUT (
		.clk, .arst_n, .portAClock, .portASelectN, .portADirection, .aWriteEnable,
		.aReadEnable, .aOffsetProgramN, .aToBResetN, .portADataIn, .portADataOut,
		.portADataOe, .aInputReady, .aOutputReady, .aToBHalfFull, .aToBAlmostFlag,
		.portBClock, .portBSelectN, .portBDirection, .bWriteEnable, .bReadEnable,
		.bOffsetProgramN, .bToAResetN, .portBDataIn, .portBDataOut, .portBDataOe,
		.bInputReady, .bOutputReady, .bToAHalfFull, .bToAAlmostFlag
	);
	bfcf_port_model #(.HALF(4)) portA (
		.clk, .portClock(portAClock), .selectN(portASelectN), .direction(portADirection),
		.writeEnable(aWriteEnable), .readEnable(aReadEnable), .programN(aOffsetProgramN),
		.dataIn(portADataIn), .dataOut(portADataOut), .dataOe(portADataOe)
	);
	bfcf_port_model #(.HALF(5)) portB (
		.clk, .portClock(portBClock), .selectN(portBSelectN), .direction(portBDirection),
		.writeEnable(bWriteEnable), .readEnable(bReadEnable), .programN(bOffsetProgramN),
		.dataIn(portBDataIn), .dataOut(portBDataOut), .dataOe(portBDataOe)
	);

	initial begin
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			conclude();
		end
	end

	////////////////////////////////////////
	task automatic check(input logic [19:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic edgesA(input int n);
		repeat (n) @(posedge portAClock);
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic edgesB(input int n);
		repeat (n) @(posedge portBClock);
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask

	// Release lands while the port A clock is low, just after its fall and away from its rising edge.
	task automatic qresetA();
		@(posedge clk);
		aToBResetN <= 1'b0;
		repeat (50) @(posedge clk);
		@(negedge portAClock);
		aToBResetN <= 1'b1;
		#1;
	endtask

	////////////////////////////////////////
	task automatic testReset();
		check({aToBAlmostFlag, bToAAlmostFlag}, 2'h3);
		check({portADataOe, portBDataOe}, 2'h3);
		repeat (50) @(posedge clk);
		fork
			begin
				@(negedge portAClock);
				aToBResetN <= 1'b1;
				#1;
				check({aInputReady, bOutputReady, aToBHalfFull}, 3'h0);
				edgesA(1);
				check(aInputReady, 1'b0);
				edgesA(1);
				check(aInputReady, 1'b1);
			end
			begin
				@(negedge portBClock);
				bToAResetN <= 1'b1;
				#1;
				check({bInputReady, aOutputReady, bToAHalfFull}, 3'h0);
				edgesB(1);
				check(bInputReady, 1'b0);
				edgesB(1);
				check(bInputReady, 1'b1);
			end
		join
		$display("test reset done");
	endtask

	task automatic testFall();
		portA.cycle(1, 1, 1, 0, 0, 18'h2a5a5);
		repeat (2) @(posedge clk);
		edgesB(2);
		check({bOutputReady, portBDataOut}, 19'h0);
		edgesB(1);
		check({bOutputReady, portBDataOut}, {1'b1, 18'h2a5a5});
		$display("test fall-through done");
	endtask

	task automatic testGate();
		portB.cycle(0, 0, 0, 1, 0, 18'h0);
		#1;
		check(portBDataOe, 1'b1);
		portB.cycle(1, 1, 0, 1, 0, 18'h0);
		portB.cycle(1, 0, 0, 0, 0, 18'h0);
		#1;
		check(portBDataOe, 1'b0);
		check({bOutputReady, portBDataOut}, {1'b1, 18'h2a5a5});
		portB.cycle(1, 0, 0, 1, 0, 18'h0);
		#1;
		check(bOutputReady, 1'b0);
		portB.cycle(1, 0, 0, 1, 0, 18'h0);
		settle();
		check({bOutputReady, portBDataOut}, {1'b0, 18'h2a5a5});
		$display("test read gating done");
	endtask

	task automatic testFull();
		qresetA();
		portA.cycle(1, 1, 0, 0, 1, 18'h3);
		portA.cycle(1, 1, 0, 0, 1, 18'h5);
		edgesA(1);
		for (int i = 0; i < 512; i++) begin
			check(aToBAlmostFlag, (i <= 3 || i >= 507));
			check(aInputReady, 1'b1);
			portA.cycle(1, 1, 1, 0, 0, 18'(i));
			settle();
		end
		edgesA(1);
		check({aInputReady, aToBAlmostFlag}, 2'h1);
		portA.cycle(1, 1, 1, 0, 0, 18'h3ffff);
		settle();
		for (int j = 0; j < 256; j++) begin
			check({bOutputReady, portBDataOut}, {1'b1, 18'(j)});
			portB.cycle(1, 0, 0, 1, 0, 18'h0);
			settle();
		end
		check(aToBHalfFull, 1'b1);
		qresetA();
		check({aInputReady, bOutputReady, aToBHalfFull, aToBAlmostFlag}, 4'h1);
		check(portBDataOut, 18'h100);
		$display("test full and reset done");
	endtask

	task automatic testBa();
		check({aOutputReady, portADataOut}, 19'h0);
		portB.cycle(1, 1, 0, 0, 1, 18'h0);
		portB.cycle(1, 1, 0, 0, 1, 18'h4);
		portB.cycle(1, 1, 1, 0, 0, 18'h11111);
		repeat (2) @(posedge clk);
		edgesA(2);
		check(aOutputReady, 1'b0);
		edgesA(1);
		check({aOutputReady, portADataOut}, {1'b1, 18'h11111});
		check(bToAAlmostFlag, 1'b0);
		portB.cycle(1, 1, 1, 0, 0, 18'h22222);
		portA.cycle(0, 0, 0, 1, 0, 18'h0);
		portA.cycle(1, 0, 0, 1, 0, 18'h0);
		#1;
		check(portADataOe, 1'b0);
		settle();
		check({aOutputReady, portADataOut}, {1'b1, 18'h22222});
		portA.cycle(1, 0, 0, 1, 0, 18'h0);
		settle();
		check({aOutputReady, portADataOut}, {1'b0, 18'h22222});
		check(bToAAlmostFlag, 1'b1);
		$display("test reverse queue done");
	endtask

	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		#1;
		testReset();
		testFall();
		testGate();
		testFull();
		testBa();
		conclude();
	end
endmodule
`default_nettype wire
